// [dv/pfc_flash_model.sv]
// behavioural parallel nor flash device facing the host controller
`timescale 1ns/1ps
module pfc_flash_model #(
	parameter int PROG_T = 20, // program time in 20 ns ticks
	parameter int ERASE_T = 100 // erase time in 20 ns ticks
)(
	input wire logic ce_b, // chip select
	input wire logic oe_b, // output enable
	input wire logic we_b, // write strobe
	input wire logic [pfc_pkg::PFC_AW-1:0] addr, // address lines
	input wire logic [pfc_pkg::PFC_DW-1:0] din, // resolved data lines
	input wire logic byte_b, // width select, high word
	input wire logic rst_b, // device reset, low
	input wire logic vpp_ok, // protect level good
	output logic [pfc_pkg::PFC_DW-1:0] q, // data lines toward host
	output logic ready // high when idle
);
	import pfc_pkg::*;
	// ==========================================
	// state
	logic [15:0] mem [int];
	logic [20:0] la = '0;
	logic [20:0] pa = '0;
	logic [15:0] pd = '0;
	logic [15:0] last = '0;
	logic [15:0] v;
	logic [7:0] c;
	logic [70:0] lock = '0;
	logic busy = 0; // powers up in read mode
	logic susp = 0;
	logic spm = 0;
	logic tog = 0;
	logic arm = 0;
	int step = 0;
	int kind = 0;
	int left = 0;
	wire wr_n = ce_b | we_b;
	wire drv = !ce_b && !oe_b && we_b && rst_b;
	assign ready = !busy;
	function automatic int sec(logic [20:0] a);
		return (a < 21'h_0_8000) ? int'(a[14:12]) : 7 + int'(a[20:15]);
	endfunction
	function automatic logic [15:0] rd(int a);
		return mem.exists(a) ? mem[a] : 16'h_FFFF; // erased reads one
	endfunction
	task automatic start(int k, int t);
		if (vpp_ok) begin
			kind = k;
			pa = la;
			pd = din;
			left = t;
			busy = 1;
		end
	endtask
	// ==========================================
	// read path; a released line shows the inverse of its last value
	always @(addr, drv, busy, tog, byte_b) begin
		v = busy ? {8'h_00, (kind == 1) ? ~pd[7] : 1'b0, tog, 6'h_00} : rd(int'(addr));
		q = drv ? v : ~last;
		if (!byte_b) q[15:8] = ~last[15:8];
		if (drv) last = q;
	end
	// each status read while busy flips the toggle bit
	always @(negedge oe_b) if (!ce_b && busy) tog = ~tog;
	// address taken at the later falling strobe
	always @(negedge wr_n) if (oe_b) la = addr;
	// decoder; data taken at first rising strobe, commands decoded from low byte only, program data as full word
	always @(posedge wr_n) if (rst_b && oe_b) begin
		c = din[7:0];
		if (busy) begin
			if (!spm && c == PFC_CODE_SUSP) susp = 1;
			if (!spm && c == PFC_CODE_RESUME) susp = 0;
		end else if (spm || arm) begin
			arm = 0;
			start(1, PROG_T); // single pulse programs even erase codes
		end else begin
			case (step)
				0: step = (c == PFC_CODE_AA && la == PFC_ADDR_U1) ? 1 : 0;
				1: step = (c == PFC_CODE_55 && la == PFC_ADDR_U2) ? 2 : 0;
				2: begin
					arm = (c == PFC_CODE_PROG);
					step = (c == PFC_CODE_ERASE) ? 3 : 0;
				end
				3: step = (c == PFC_CODE_AA) ? 4 : 0;
				4: step = (c == PFC_CODE_55) ? 5 : 0;
				default: begin
					step = 0;
					if (c == PFC_CODE_CHIP) start(2, ERASE_T);
					if (c == PFC_CODE_SECTOR) start(3, lock[sec(la)] ? 50 : ERASE_T);
					if (c == PFC_CODE_SPM) spm = 1;
				end
			endcase
		end
	end
	// internal timer, frozen while suspended
	always #20 if (busy && !susp) begin
		if (left > 0) left--;
		else begin
			busy = 0;
			if (kind == 1) mem[int'(pa)] = rd(int'(pa)) & pd; // only clears bits
			else foreach (mem[k]) if (!lock[sec(21'(k))] && (kind == 2 || sec(21'(k)) == sec(pa))) mem[k] = 16'h_FFFF;
		end
	end
	// reset aborts work, ends single-pulse mode and unlocks all
	always @(negedge rst_b) begin
		busy = 0;
		susp = 0;
		spm = 0;
		arm = 0;
		step = 0;
		lock = '0;
	end
endmodule

// [dv/test_pfc_host.sv]
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module test_pfc_host;
	import pfc_pkg::*;
	logic clk = 0;
	logic rst_b = 0;
	logic req = 0;
	logic byte_mode = 0;
	logic vpp = 1;
	pfc_op_e op = PFC_OP_READ;
	logic [20:0] ra = '0;
	logic [15:0] rd = '0;
	logic [31:0] r;
	logic [20:0] al [3];
	wire busy, ack, err, spm, ce_b, oe_b, we_b, doe_b, byte_b, frst_b, ready;
	wire [20:0] fa;
	wire [15:0] rdata, dout, q;
	wire [15:0] din = !doe_b ? dout : q; // resolved data lines
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed = 59;
	int rlow = 0;
	logic [15:0] ref_mem [int];
	pfc_host #(.POLL_LIMIT(50)) i_pfc_host (.clk(clk), .rst_b(rst_b), .req(req), .op(op), .req_addr(ra),
		.req_data(rd), .byte_mode(byte_mode), .busy_r(busy), .ack_r(ack), .rdata_r(rdata), .err_r(err),
		.spm_r(spm), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .addr(fa), .data_lines_o(dout),
		.data_lines_oe_b(doe_b), .data_lines_i(din), .byte_b_r(byte_b), .frst_b_r(frst_b),
		.ready_i(ready), .vpp_ok_i(vpp));
	pfc_flash_model u_flash (.ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .addr(fa), .din(din), .byte_b(byte_b),
		.rst_b(frst_b), .vpp_ok(vpp), .q(q), .ready(ready));
	// ==========================================
	// clock, timeout, reset width and contention watch
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (!frst_b) rlow++;
		if (!doe_b) cmp_b(u_flash.drv, 1'b0);
		if (cyc == 20000) begin
			miscompares++;
			conclude;
		end
	end
	// ==========================================
	// reference memory and checks
	function automatic int rsec(logic [20:0] a);
		return (a < 21'h_0_8000) ? int'(a[14:12]) : 7 + int'(a[20:15]);
	endfunction
	function automatic logic [15:0] rrd(logic [20:0] a);
		return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 16'h_FFFF;
	endfunction
	task automatic cmp(logic [15:0] got, logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t data got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_b(logic got, logic exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t flag got %b expected %b", $time, got, exp);
		end
	endtask
	// one request, held one cycle, then a bounded wait for the answer
	task automatic do_op(pfc_op_e o, logic [20:0] a, logic [15:0] d);
		int n;
		n = 0;
		@(negedge clk);
		op = o;
		ra = a;
		rd = d;
		req = 1;
		@(negedge clk);
		req = 0;
		cmp_b(busy, 1'b1);
		while (ack !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		cmp_b(ack, 1'b1);
		cmp_b(busy, 1'b0);
		if (o == PFC_OP_PROG && err === 1'b0) ref_mem[int'(a)] = rrd(a) & d;
	endtask
	task automatic conclude;
		if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (12) @(negedge clk);
		rst_b = 1;
		repeat (3) @(negedge clk);
		cmp_b(byte_b, 1'b1);
		cmp_b(frst_b, 1'b1);
		// random words programmed twice, so the second only clears bits
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			al[i] = r[20:0];
			do_op(PFC_OP_READ, al[i], 16'h_0000);
			cmp(rdata, 16'h_FFFF);
			r = $random(seed);
			do_op(PFC_OP_PROG, al[i], r[15:0]);
			cmp_b(err, 1'b0);
			r = $random(seed);
			do_op(PFC_OP_PROG, al[i], r[15:0]);
			do_op(PFC_OP_READ, al[i], 16'h_0000);
			cmp(rdata, rrd(al[i]));
		end
		// sector erase touches only the addressed sector
		do_op(PFC_OP_SECT_ERASE, al[0], 16'h_0000);
		foreach (ref_mem[k]) if (rsec(21'(k)) == rsec(al[0])) ref_mem[k] = 16'h_FFFF;
		for (int i = 0; i < 2; i++) begin
			do_op(PFC_OP_READ, al[i], 16'h_0000);
			cmp(rdata, rrd(al[i]));
		end
		// protect input low refuses programming
		vpp = 0;
		repeat (4) @(negedge clk);
		do_op(PFC_OP_PROG, al[1], 16'h_0000);
		cmp_b(err, 1'b1);
		vpp = 1;
		repeat (4) @(negedge clk);
		do_op(PFC_OP_READ, al[1], 16'h_0000);
		cmp(rdata, rrd(al[1]));
		// suspend and resume with nothing running
		do_op(PFC_OP_SUSPEND, al[1], 16'h_0000);
		do_op(PFC_OP_RESUME, al[1], 16'h_0000);
		cmp_b(err, 1'b0);
		// byte width: low byte only
		byte_mode = 1;
		repeat (3) @(negedge clk);
		cmp_b(byte_b, 1'b0);
		do_op(PFC_OP_READ, al[1], 16'h_0000);
		cmp({8'h_00, rdata[7:0]}, {8'h_00, rrd(al[1]) & 16'h_00FF});
		byte_mode = 0;
		repeat (3) @(negedge clk);
		// single-pulse mode, entered as programming equipment would
		do_op(PFC_OP_SPM_ENTER, 21'h_0_0000, 16'h_0000);
		cmp_b(spm, 1'b1);
		r = $random(seed);
		do_op(PFC_OP_PROG, al[2], r[15:0]);
		do_op(PFC_OP_READ, al[2], 16'h_0000);
		cmp(rdata, rrd(al[2]));
		do_op(PFC_OP_CHIP_ERASE, al[2], 16'h_0000);
		cmp_b(err, 1'b1);
		do_op(PFC_OP_SUSPEND, al[2], 16'h_0000);
		cmp_b(err, 1'b1);
		rlow = 0;
		do_op(PFC_OP_RESET, al[2], 16'h_0000);
		cmp_b(spm, 1'b0);
		cmp_b(rlow >= PFC_RST_CYC, 1'b1);
		do_op(PFC_OP_READ, al[2], 16'h_0000);
		cmp(rdata, rrd(al[2]));
		// chip erase clears everything unlocked
		do_op(PFC_OP_CHIP_ERASE, al[1], 16'h_0000);
		ref_mem.delete();
		do_op(PFC_OP_READ, al[1], 16'h_0000);
		cmp(rdata, 16'h_FFFF);
		conclude;
	end
endmodule

// [logic/pfc_bus_cycle.sv]
// one asynchronous bus cycle on the flash pins: write or read
`timescale 1ns/1ps
module pfc_bus_cycle
	import pfc_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, low
	input wire logic start, // one-cycle start pulse
	input wire logic wr, // 1 write, 0 read
	input wire logic [pfc_pkg::PFC_AW-1:0] addr, // word address
	input wire logic [pfc_pkg::PFC_DW-1:0] wdata, // write data
	input wire logic [pfc_pkg::PFC_DW-1:0] pin_din_s, // synchronised data lines
	output logic ce_b_r, // chip select
	output logic oe_b_r, // output enable
	output logic we_b_r, // write strobe
	output logic [pfc_pkg::PFC_AW-1:0] addr_r, // address lines
	output logic [pfc_pkg::PFC_DW-1:0] dout_r, // data lines out
	output logic doe_b_r, // data output enable, low drives
	output logic [pfc_pkg::PFC_DW-1:0] rdata_r, // read result
	output logic done_r // one-cycle completion pulse
);
	import pfc_pkg::*;
	typedef enum logic [1:0] {PFC_BC_IDLE, PFC_BC_SETUP, PFC_BC_PULSE, PFC_BC_HOLD} pfc_bc_e;
	pfc_bc_e st_r, st_nxt;
	logic [PFC_CW-1:0] cnt_r, cnt_nxt;
	logic ce_nxt, oe_nxt, we_nxt, doe_nxt, done_nxt, wr_r, wr_nxt;
	logic [PFC_AW-1:0] a_nxt;
	logic [PFC_DW-1:0] d_nxt, rd_nxt;

	// ==========================================
	// cycle sequencer: address first, then strobe, data held past rising edge
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		ce_nxt = ce_b_r;
		oe_nxt = oe_b_r;
		we_nxt = we_b_r;
		doe_nxt = doe_b_r;
		done_nxt = 1'b0;
		wr_nxt = wr_r;
		a_nxt = addr_r;
		d_nxt = dout_r;
		rd_nxt = rdata_r;
		case (st_r)
			PFC_BC_IDLE: begin
				if (start) begin
					// address settles before the later falling strobe
					a_nxt = addr;
					d_nxt = wdata;
					wr_nxt = wr;
					ce_nxt = 1'b0;
					doe_nxt = ~wr; // never drive while reading
					st_nxt = PFC_BC_SETUP;
				end
			end
			PFC_BC_SETUP: begin
				// write: write strobe low, output enable high; read: output enable low, write strobe high
				we_nxt = ~wr_r;
				oe_nxt = wr_r;
				cnt_nxt = wr_r ? PFC_CW'(PFC_STROBE_CYC) : PFC_CW'(PFC_READ_CYC);
				st_nxt = PFC_BC_PULSE;
			end
			PFC_BC_PULSE: begin
				if (cnt_r > PFC_CW'(1)) begin
					cnt_nxt = cnt_r - PFC_CW'(1);
				end else begin
					if (!wr_r) begin
						rd_nxt = pin_din_s;
					end
					// rising write strobe latches data, data still driven
					we_nxt = 1'b1;
					oe_nxt = 1'b1;
					st_nxt = PFC_BC_HOLD;
				end
			end
			PFC_BC_HOLD: begin
				ce_nxt = 1'b1;
				doe_nxt = 1'b1;
				done_nxt = 1'b1;
				st_nxt = PFC_BC_IDLE;
			end
			default: st_nxt = PFC_BC_IDLE;
		endcase
	end

	// ==========================================
	// registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= PFC_BC_IDLE;
			cnt_r <= '0;
			ce_b_r <= 1'b1;
			oe_b_r <= 1'b1;
			we_b_r <= 1'b1;
			doe_b_r <= 1'b1;
			done_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= '0;
			dout_r <= '0;
			rdata_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			ce_b_r <= ce_nxt;
			oe_b_r <= oe_nxt;
			we_b_r <= we_nxt;
			doe_b_r <= doe_nxt;
			done_r <= done_nxt;
			wr_r <= wr_nxt;
			addr_r <= a_nxt;
			dout_r <= d_nxt;
			rdata_r <= rd_nxt;
		end
	end

	// ==========================================
	// checks
	bus_excl_a: assert property (@(posedge clk) disable iff (!rst_b)
		!(oe_b_r == 1'b0 && we_b_r == 1'b0)) else $error("write and read strobe low together");
	strobe_ce_a: assert property (@(posedge clk) disable iff (!rst_b)
		!we_b_r |-> !ce_b_r) else $error("write strobe without chip select");
	data_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(we_b_r) |-> !doe_b_r && !ce_b_r) else $error("data released before strobe rise");
	read_no_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
		!oe_b_r |-> doe_b_r) else $error("driving data during read");
endmodule

// [logic/pfc_host.sv]
// host controller issuing command sequences to a parallel nor flash
`timescale 1ns/1ps
// Overview of operation
// - single-pulse mode ends only on power-down or long reset pulse
// - issue single-pulse entry only from programming equipment
// - each command cycle is a write-strobe low pulse, output-enable high
// - erased cells read one; programming only clears bits
module pfc_host
	import pfc_pkg::*;
#(
	parameter int POLL_LIMIT = 100000 // polls before declaring timeout
)(
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, low
	input wire logic req, // one-cycle request
	input wire pfc_pkg::pfc_op_e op, // requested operation
	input wire logic [pfc_pkg::PFC_AW-1:0] req_addr, // word or sector address
	input wire logic [pfc_pkg::PFC_DW-1:0] req_data, // program data
	input wire logic byte_mode, // 1 selects byte width
	output logic busy_r, // request in progress
	output logic ack_r, // one-cycle completion pulse
	output logic [pfc_pkg::PFC_DW-1:0] rdata_r, // read data
	output logic err_r, // refused or timed out
	output logic spm_r, // single-pulse mode active
	output logic ce_b, // flash chip select
	output logic oe_b, // flash output enable
	output logic we_b, // flash write strobe
	output logic [pfc_pkg::PFC_AW-1:0] addr, // flash address lines
	output logic [pfc_pkg::PFC_DW-1:0] data_lines_o, // data lines out
	output logic data_lines_oe_b, // low while host drives data lines
	input wire logic [pfc_pkg::PFC_DW-1:0] data_lines_i, // data lines in
	output logic byte_b_r, // width select, high for word
	output logic frst_b_r, // flash reset, low
	input wire logic ready_i, // ready/busy pin, high ready
	input wire logic vpp_ok_i // protect level above enable
);
	import pfc_pkg::*;
	typedef enum logic [2:0] {PFC_S_IDLE, PFC_S_SEQ, PFC_S_POLL, PFC_S_RST, PFC_S_DONE} pfc_st_e;
	pfc_st_e st_r, st_nxt;
	logic [2:0] idx_r, idx_nxt, n_r, n_nxt;
	pfc_op_e op_r, op_nxt;
	logic [PFC_AW-1:0] a_r, a_nxt;
	logic [PFC_DW-1:0] d_r, d_nxt, rd_nxt, prev_r, prev_nxt;
	logic first_r, first_nxt, busy_nxt, ack_nxt, err_nxt, spm_nxt, frst_nxt, byte_nxt;
	logic [PFC_CW-1:0] rcnt_r, rcnt_nxt;
	logic [31:0] poll_r, poll_nxt;
	logic bc_start, bc_wr, bc_done;
	logic [PFC_AW-1:0] bc_a;
	logic [PFC_DW-1:0] bc_d, bc_rd;
	logic [PFC_DW-1:0] din_m_r, din_s_r;
	logic rdy_m_r, rdy_s_r, vpp_m_r, vpp_s_r;

	// ==========================================
	// two-flop synchronisers for pins from the flash
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			din_m_r <= '0;
			din_s_r <= '0;
			rdy_m_r <= 1'b0;
			rdy_s_r <= 1'b0;
			vpp_m_r <= 1'b0;
			vpp_s_r <= 1'b0;
		end else begin
			din_m_r <= data_lines_i;
			din_s_r <= din_m_r;
			rdy_m_r <= ready_i;
			rdy_s_r <= rdy_m_r;
			vpp_m_r <= vpp_ok_i;
			vpp_s_r <= vpp_m_r;
		end
	end

	// ==========================================
	// bus cycle engine
	pfc_bus_cycle i_pfc_bus_cycle (
		.clk(clk),
		.rst_b(rst_b),
		.start(bc_start),
		.wr(bc_wr),
		.addr(bc_a),
		.wdata(bc_d),
		.pin_din_s(din_s_r),
		.ce_b_r(ce_b),
		.oe_b_r(oe_b),
		.we_b_r(we_b),
		.addr_r(addr),
		.dout_r(data_lines_o),
		.doe_b_r(data_lines_oe_b),
		.rdata_r(bc_rd),
		.done_r(bc_done)
	);

	// ==========================================
	// sequence tables: cycle i of each command, command codes in low byte
	function automatic logic [PFC_AW+PFC_DW-1:0] seq_cycle(pfc_op_e o, logic [2:0] i,
			logic [PFC_AW-1:0] a, logic [PFC_DW-1:0] d);
		logic [7:0] c;
		logic [PFC_AW-1:0] ad;
		logic odd;
		// the second unlock pair sits at cycles 3 and 4, so parity flips after cycle 2
		odd = i[0] ^ (i > 3'd2);
		c = (odd == 1'b0) ? PFC_CODE_AA : PFC_CODE_55;
		ad = (odd == 1'b0) ? PFC_ADDR_U1 : PFC_ADDR_U2;
		if (i == 3'd2) begin
			c = (o == PFC_OP_PROG) ? PFC_CODE_PROG : PFC_CODE_ERASE;
			ad = PFC_ADDR_U1;
		end
		if (i == 3'd5) begin
			c = (o == PFC_OP_CHIP_ERASE) ? PFC_CODE_CHIP :
				(o == PFC_OP_SPM_ENTER) ? PFC_CODE_SPM : PFC_CODE_SECTOR;
			ad = (o == PFC_OP_SECT_ERASE) ? a : PFC_ADDR_U1;
		end
		if (o == PFC_OP_PROG && i == 3'd3) begin
			return {a, d};
		end
		if (o == PFC_OP_SUSPEND) begin
			c = PFC_CODE_SUSP;
		end
		if (o == PFC_OP_RESUME) begin
			c = PFC_CODE_RESUME;
		end
		return {ad, 8'h_00, c};
	endfunction

	// ==========================================
	// operation sequencer
	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		n_nxt = n_r;
		op_nxt = op_r;
		a_nxt = a_r;
		d_nxt = d_r;
		rd_nxt = rdata_r;
		prev_nxt = prev_r;
		first_nxt = first_r;
		busy_nxt = busy_r;
		ack_nxt = 1'b0;
		err_nxt = err_r;
		spm_nxt = spm_r;
		frst_nxt = frst_b_r;
		byte_nxt = ~byte_mode;
		rcnt_nxt = rcnt_r;
		poll_nxt = poll_r;
		bc_start = 1'b0;
		bc_wr = 1'b0;
		bc_a = a_r;
		bc_d = d_r;
		{bc_a, bc_d} = seq_cycle(op_r, idx_r, a_r, d_r);
		case (st_r)
			PFC_S_IDLE: begin
				if (req) begin
					op_nxt = op;
					a_nxt = req_addr;
					d_nxt = req_data;
					idx_nxt = '0;
					first_nxt = 1'b1;
					poll_nxt = '0;
					busy_nxt = 1'b1;
					err_nxt = 1'b0;
					st_nxt = PFC_S_SEQ;
					case (op)
						PFC_OP_READ: n_nxt = 3'd0;
						// single-pulse mode: one write, no unlock
						PFC_OP_PROG: n_nxt = spm_r ? 3'd0 : 3'd3; // only clears bits, caller erases first
						PFC_OP_SUSPEND, PFC_OP_RESUME: n_nxt = 3'd0;
						PFC_OP_RESET: begin
							// long reset pulse ends single-pulse mode
							frst_nxt = 1'b0;
							rcnt_nxt = PFC_CW'(PFC_RST_CYC);
							st_nxt = PFC_S_RST;
						end
						default: n_nxt = 3'd5;
					endcase
					// refuse program and erase without protect level
					if (!vpp_s_r && (op == PFC_OP_PROG || op == PFC_OP_CHIP_ERASE
							|| op == PFC_OP_SECT_ERASE)) begin
						err_nxt = 1'b1;
						st_nxt = PFC_S_DONE;
					end
					// erase and suspend are program data in single-pulse mode
					if (spm_r && op != PFC_OP_READ && op != PFC_OP_PROG && op != PFC_OP_RESET) begin
						err_nxt = 1'b1;
						st_nxt = PFC_S_DONE;
					end
				end
			end
			PFC_S_SEQ: begin
				bc_start = !first_r ? 1'b0 : 1'b1;
				bc_wr = (op_r != PFC_OP_READ);
				// plain reads and single pulses go straight to the caller's address
				if (op_r == PFC_OP_READ || (spm_r && op_r == PFC_OP_PROG)) begin
					bc_a = a_r;
					bc_d = d_r;
				end
				first_nxt = 1'b0;
				if (bc_done) begin
					if (op_r == PFC_OP_READ) begin
						rd_nxt = bc_rd;
						st_nxt = PFC_S_DONE;
					end else if (idx_r == n_r) begin
						if (op_r == PFC_OP_SPM_ENTER) begin
							spm_nxt = 1'b1; // entry meant for programming equipment only
						end
						first_nxt = 1'b1;
						st_nxt = (op_r == PFC_OP_SUSPEND || op_r == PFC_OP_RESUME
							|| op_r == PFC_OP_SPM_ENTER) ? PFC_S_DONE : PFC_S_POLL;
					end else begin
						idx_nxt = idx_r + 3'd1;
						first_nxt = 1'b1;
					end
				end
			end
			PFC_S_POLL: begin
				// read repeatedly until the status bit stops toggling
				bc_start = first_r;
				bc_wr = 1'b0;
				bc_a = a_r;
				first_nxt = 1'b0;
				if (bc_done) begin
					poll_nxt = poll_r + 32'd1;
					prev_nxt = bc_rd;
					first_nxt = 1'b1;
					if (poll_r != 32'd0 && rdy_s_r
							&& bc_rd[PFC_TOGGLE_BIT] == prev_r[PFC_TOGGLE_BIT]) begin
						rd_nxt = bc_rd;
						st_nxt = PFC_S_DONE;
					end else if (poll_r == 32'(POLL_LIMIT)) begin
						err_nxt = 1'b1;
						st_nxt = PFC_S_DONE;
					end
				end
			end
			PFC_S_RST: begin
				if (rcnt_r > PFC_CW'(0)) begin
					rcnt_nxt = rcnt_r - PFC_CW'(1);
				end else begin
					frst_nxt = 1'b1;
					spm_nxt = 1'b0;
					st_nxt = PFC_S_DONE;
				end
			end
			PFC_S_DONE: begin
				ack_nxt = 1'b1;
				busy_nxt = 1'b0;
				st_nxt = PFC_S_IDLE;
			end
			default: st_nxt = PFC_S_IDLE;
		endcase
	end

	// ==========================================
	// registers; reset idles the host with flash reset held high, so the flash keeps its mode and any partial command
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= PFC_S_IDLE;
			idx_r <= '0;
			n_r <= '0;
			op_r <= PFC_OP_READ;
			a_r <= '0;
			d_r <= '0;
			rdata_r <= '0;
			prev_r <= '0;
			first_r <= 1'b0;
			busy_r <= 1'b0;
			ack_r <= 1'b0;
			err_r <= 1'b0;
			spm_r <= 1'b0;
			frst_b_r <= 1'b1;
			byte_b_r <= 1'b1;
			rcnt_r <= '0;
			poll_r <= '0;
		end else begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			n_r <= n_nxt;
			op_r <= op_nxt;
			a_r <= a_nxt;
			d_r <= d_nxt;
			rdata_r <= rd_nxt;
			prev_r <= prev_nxt;
			first_r <= first_nxt;
			busy_r <= busy_nxt;
			ack_r <= ack_nxt;
			err_r <= err_nxt;
			spm_r <= spm_nxt;
			frst_b_r <= frst_nxt;
			byte_b_r <= byte_nxt;
			rcnt_r <= rcnt_nxt;
			poll_r <= poll_nxt;
		end
	end

	// ==========================================
	// checks
	// flash reset held low for at least 25 clock edges, 500 ns
	sequence rst_low_s;
		!frst_b_r [*8] ##1 !frst_b_r [*8] ##1 !frst_b_r [*8] ##1 !frst_b_r;
	endsequence
	rst_width_a: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(frst_b_r) |-> rst_low_s ##[1:4] frst_b_r) else $error("flash reset pulse too short");
	spm_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(spm_r) |-> !$past(frst_b_r)) else $error("single-pulse mode left without reset");
	vpp_refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_r == PFC_S_IDLE && req && op == PFC_OP_PROG && !vpp_s_r) |=> ##1 ack_r && err_r)
		else $error("program not refused at low protect level");
	ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
		ack_r |=> !ack_r && !busy_r) else $error("ack not a single pulse");
	byte_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
		byte_b_r == !$past(byte_mode)) else $error("width select wrong");
endmodule

// [logic/pfc_pkg.sv]
// shared constants for the parallel flash host controller
package pfc_pkg;
	localparam int PFC_AW = 21; // word address width
	localparam int PFC_DW = 16; // data line width
	localparam int PFC_CLK_MHZ = 50; // system clock rate
	// bus timing in ns
	localparam int PFC_T_STROBE_NS = 60; // least strobe low time
	localparam int PFC_T_READ_NS = 85; // access time
	localparam int PFC_T_RST_NS = 500; // least reset low pulse
	localparam int PFC_STROBE_CYC = (PFC_T_STROBE_NS * PFC_CLK_MHZ + 999) / 1000;
	localparam int PFC_READ_CYC = (PFC_T_READ_NS * PFC_CLK_MHZ + 999) / 1000 + 1;
	localparam int PFC_RST_CYC = (PFC_T_RST_NS * PFC_CLK_MHZ + 999) / 1000;
	localparam int PFC_CW = 8; // cycle counter width
	// command cycle data codes and unlock addresses
	localparam logic [7:0] PFC_CODE_AA = 8'h_AA;
	localparam logic [7:0] PFC_CODE_55 = 8'h_55;
	localparam logic [7:0] PFC_CODE_ERASE = 8'h_80;
	localparam logic [7:0] PFC_CODE_CHIP = 8'h_10;
	localparam logic [7:0] PFC_CODE_SECTOR = 8'h_30;
	localparam logic [7:0] PFC_CODE_PROG = 8'h_A0;
	localparam logic [7:0] PFC_CODE_SPM = 8'h_A5; // single-pulse mode entry, last cycle
	localparam logic [7:0] PFC_CODE_SUSP = 8'h_B0;
	localparam logic [7:0] PFC_CODE_RESUME = 8'h_D0;
	localparam logic [20:0] PFC_ADDR_U1 = 21'h_0_0555;
	localparam logic [20:0] PFC_ADDR_U2 = 21'h_0_0AAA;
	localparam int PFC_TOGGLE_BIT = 6; // toggle_status_bit position
	// host operations
	typedef enum logic [2:0] {
		PFC_OP_READ, PFC_OP_PROG, PFC_OP_CHIP_ERASE, PFC_OP_SECT_ERASE,
		PFC_OP_SUSPEND, PFC_OP_RESUME, PFC_OP_SPM_ENTER, PFC_OP_RESET
	} pfc_op_e;
endpackage
